/* File: src/ufo_pkg.sv */
// Constants and carrier types for the serial flag and overrun controller
package ufo_pkg;
   localparam logic [12:0] UFO_DIV_RST   = 13'h0000;
   localparam logic [3:0]  UFO_OS_LAST   = 4'hf;
   localparam logic [3:0]  UFO_OS_SAMPLE = 4'h7;
   localparam logic [3:0]  UFO_OS_LOAD   = 4'h8;
   localparam logic [3:0]  UFO_FRAME8    = 4'ha;
   localparam logic [3:0]  UFO_FRAME9    = 4'hb;
   localparam logic [7:0]  UFO_MAP_BYTES = 8'h20;

   typedef enum logic [2:0] {TX_OFF, TX_IDLE, TX_PRE, TX_START, TX_DATA, TX_STOP} ufo_tx_t;
   typedef enum logic [1:0] {RX_IDLE, RX_START, RX_DATA, RX_STOP} ufo_rx_t;

   typedef struct packed {
      logic             tx_enable;
      logic             nine_bit;
      logic             smartcard_mode_enable;
      logic             smartcard_protocol_select;
      logic             overflow_nack_enable;
      logic             rx_standby;
      logic [1:0]       match_en;
      logic [7:0]       match_addr_one;
      logic [7:0]       match_addr_two;
      logic [2:0][15:0] wait_limit;
   } ufo_cfg_t;

   typedef struct packed {
      logic       div_hi_wr;
      logic       div_lo_wr;
      logic       tx_wr;
      logic       rx_rd;
      logic       or_clr;
      logic       idle_clr;
      logic [2:0] wait_clr;
   } ufo_cmd_t;

   typedef struct packed {
      logic tx_buffer_empty_flag;
      logic rx_full_flag;
      logic overrun_flag;
      logic idle_flag;
      logic match_hit;
      logic bus_error;
      logic char_wait_flag;
      logic block_wait_flag;
      logic general_wait_flag;
   } ufo_stat_t;

   typedef struct packed {
      logic [12:0]      div;
      logic [4:0]       div_hi;
      logic [12:0]      bcnt;
      logic [3:0]       etu_os;
      logic             te_q;
      logic             pre_pend;
      ufo_tx_t          tx_st;
      logic [3:0]       tx_os;
      logic [3:0]       tx_bit;
      logic [8:0]       tx_sh;
      logic             sh_valid;
      logic [8:0]       tx_buf;
      logic             tx_full;
      logic             tx_pin;
      logic             rx_s1;
      logic             rx_s2;
      ufo_rx_t          rx_st;
      logic [3:0]       rx_os;
      logic [3:0]       rx_bit;
      logic [8:0]       rx_sh;
      logic [8:0]       rx_buf;
      logic             rx_full;
      logic             overrun;
      logic             idle_flag;
      logic [7:0]       idle_cnt;
      logic             armed;
      logic             nack_commit;
      logic             nack_on;
      logic [3:0]       nack_os;
      logic [7:0]       nack_cnt;
      logic             match_hit;
      logic [2:0][15:0] wcnt;
      logic [2:0]       wflag;
      logic             bus_err;
   } ufo_state_t;
endpackage : ufo_pkg

/* File: src/ufo_core.sv */
// Serial transceiver flag, preamble, overrun, nack, match and wait-timer logic
`timescale 1ns/10ps
module ufo_core
   import ufo_pkg::*;
(
   input  wire logic                sys_clk,         // 200 MHz module clock
   input  wire logic                rst,             // Synchronous reset, active high
   input  wire logic                ce,              // Clock enable, freezes all state
   input  wire ufo_pkg::ufo_cfg_t   cfg,             // Configuration levels
   input  wire ufo_pkg::ufo_cmd_t   cmd,             // One-cycle command strobes
   input  wire logic [7:0]          div_data,        // Divisor byte for either write
   input  wire logic [8:0]          tx_data,         // Word to send, bit 8 is ninth_tx_bit
   input  wire logic                reg_sel,         // Register access strobe
   input  wire logic [7:0]          reg_addr,        // Register access byte address
   input  wire logic                rx_pin,          // Serial line in, asynchronous
   output      logic                tx_pin,          // Serial line out
   output      logic [8:0]          rx_data,         // Last stored word
   output      logic [7:0]          rx_nack_counter, // Count of nacked words
   output      ufo_pkg::ufo_stat_t  stat             // Status flags
);
   import ufo_pkg::*;

   ufo_state_t r;
   ufo_state_t n;
   logic       tick;
   logic       etu;
   logic       tx_end;
   logic       tx_go;
   logic       rx_samp;
   logic       rx_end;
   logic       rx_go;
   logic       rxl;
   logic       word_done;
   logic       idle_hit;
   logic       full_now;
   logic       sc_nack;
   logic [3:0] nbits;
   logic [3:0] frame;
   logic [2:0] viol;
   logic [2:0] wrst;

   always_comb begin
      n         = r;
      tick      = 1'b0;
      tx_go     = 1'b0;
      rx_go     = 1'b0;
      word_done = 1'b0;
      nbits     = cfg.nine_bit ? 4'h9 : 4'h8;
      frame     = cfg.nine_bit ? UFO_FRAME9 : UFO_FRAME8;
      sc_nack   = cfg.smartcard_mode_enable && !cfg.smartcard_protocol_select &&
                  cfg.overflow_nack_enable;

      // Low byte commits the staged high byte, so a lone high write changes nothing
      if (cmd.div_hi_wr) n.div_hi = div_data[4:0];
      if (cmd.div_lo_wr) n.div = {r.div_hi, div_data};
      if (r.div == 13'h0000) begin
         n.bcnt = 13'h0000;
      end else if (r.bcnt >= r.div - 13'h0001) begin
         n.bcnt = 13'h0000;
         tick   = 1'b1;
      end else begin
         n.bcnt = r.bcnt + 13'h0001;
      end
      // A new divisor restarts the count so no stale count meets a smaller divisor
      if (cmd.div_lo_wr) n.bcnt = 13'h0000;
      if (tick) n.etu_os = r.etu_os + 4'h1;
      etu = tick && (r.etu_os == UFO_OS_LAST);

      // Transmitter
      n.te_q = cfg.tx_enable;
      if (cfg.tx_enable && !r.te_q) n.pre_pend = 1'b1;
      if (cmd.tx_wr && !r.tx_full) begin
         n.tx_buf  = tx_data;
         n.tx_full = 1'b1;
      end
      if (tick) n.tx_os = r.tx_os + 4'h1;
      tx_end = tick && (r.tx_os == UFO_OS_LAST);
      unique case (r.tx_st)
         TX_OFF: begin
            n.tx_os = 4'h0;
            if (cfg.tx_enable) n.tx_st = TX_IDLE;
         end
         TX_IDLE: begin
            n.tx_os  = 4'h0;
            n.tx_bit = 4'h0;
            if (!cfg.tx_enable) begin
               n.tx_st = TX_OFF;
            // A word already in the shifter ends the old message before the preamble
            end else if (r.sh_valid) begin
               n.tx_st = TX_START;
               tx_go   = 1'b1;
            end else if (r.pre_pend) begin
               n.tx_st = TX_PRE;
            end else if (r.tx_full) begin
               n.tx_sh    = r.tx_buf;
               n.sh_valid = 1'b1;
               n.tx_full  = 1'b0;
            end
         end
         TX_PRE: begin
            if (tx_end) begin
               n.tx_bit = r.tx_bit + 4'h1;
               if (r.tx_bit == frame - 4'h1) begin
                  n.pre_pend = 1'b0;
                  n.tx_st    = TX_IDLE;
               end
            end
         end
         TX_START: begin
            if (tx_end) begin
               n.tx_st  = TX_DATA;
               n.tx_bit = 4'h0;
            end
         end
         TX_DATA: begin
            if (tx_end) begin
               if (r.tx_bit == nbits - 4'h1) begin
                  n.tx_st    = TX_STOP;
                  n.sh_valid = 1'b0;
               end else begin
                  n.tx_bit = r.tx_bit + 4'h1;
               end
            end
         end
         TX_STOP: begin
            // Early load lets the next frame follow with no idle gap
            // A queued preamble holds the next word back until it has gone out
            if (tick && r.tx_os == UFO_OS_LOAD && r.tx_full && !r.sh_valid &&
                !r.pre_pend) begin
               n.tx_sh    = r.tx_buf;
               n.sh_valid = 1'b1;
               n.tx_full  = 1'b0;
            end
            if (tx_end) n.tx_st = TX_IDLE;
         end
         default: n.tx_st = TX_OFF;
      endcase

      // Receiver
      n.rx_s1  = rx_pin;
      n.rx_s2  = r.rx_s1;
      rxl      = r.rx_s2;
      full_now = r.rx_full && !cmd.rx_rd;
      if (cmd.rx_rd) n.rx_full = 1'b0;
      if (cmd.or_clr) n.overrun = 1'b0;
      if (cmd.idle_clr) n.idle_flag = 1'b0;
      n.match_hit = 1'b0;
      if (tick) n.rx_os = r.rx_os + 4'h1;
      rx_samp = tick && (r.rx_os == UFO_OS_SAMPLE);
      rx_end  = tick && (r.rx_os == UFO_OS_LAST);
      unique case (r.rx_st)
         RX_IDLE: begin
            n.rx_os = 4'h0;
            if (!rxl) begin
               n.rx_st = RX_START;
               rx_go   = 1'b1;
            end
         end
         RX_START: begin
            n.rx_sh = 9'h000;
            if (rx_samp && rxl) begin
               n.rx_st = RX_IDLE;
            end else if (rx_end) begin
               n.rx_st  = RX_DATA;
               n.rx_bit = 4'h0;
            end
         end
         RX_DATA: begin
            if (rx_samp) begin
               n.rx_sh[r.rx_bit] = rxl;
               // Commit happens at the last data bit, before the word is complete
               if (r.rx_bit == nbits - 4'h1 && sc_nack && full_now)
                  n.nack_commit = 1'b1;
            end
            if (rx_end) begin
               if (r.rx_bit == nbits - 4'h1) n.rx_st = RX_STOP;
               else n.rx_bit = r.rx_bit + 4'h1;
            end
         end
         RX_STOP: begin
            if (rx_samp) begin
               word_done = 1'b1;
               n.rx_st   = RX_IDLE;
            end
         end
      endcase

      if (word_done) begin
         n.nack_commit = 1'b0;
         if (r.nack_commit) begin
            n.nack_cnt = r.nack_cnt + 8'h01;
            n.nack_on  = 1'b1;
            n.nack_os  = 4'h0;
            if (full_now) n.overrun = 1'b1;
         end else if (!r.overrun && full_now) begin
            n.overrun = 1'b1;
         end else if (!r.overrun) begin
            n.rx_buf  = r.rx_sh;
            n.rx_full = 1'b1;
            n.match_hit = (cfg.match_en[0] && r.rx_sh[7:0] == cfg.match_addr_one) ||
                          (cfg.match_en[1] && r.rx_sh[7:0] == cfg.match_addr_two);
         end
      end
      if (r.nack_on && tick) begin
         n.nack_os = r.nack_os + 4'h1;
         if (r.nack_os == UFO_OS_LAST) n.nack_on = 1'b0;
      end

      // Idle detection needs a low bit since the last one, also under rx_standby
      idle_hit = r.armed && (r.rx_st == RX_IDLE) && (r.idle_cnt >= {frame, 4'h0});
      if (idle_hit) begin
         n.armed = 1'b0;
         if (!r.overrun) n.idle_flag = 1'b1;
      end
      // A low sample in the detecting cycle must still arm the next detection
      if (!rxl) begin
         n.idle_cnt = 8'h00;
         n.armed    = 1'b1;
      end else if (tick && r.idle_cnt != 8'hff) begin
         n.idle_cnt = r.idle_cnt + 8'h01;
      end

      // Wait timers: 0 char, 1 block, 2 general; counted in bit times
      wrst = {rx_go | tx_go, tx_go, rx_go};
      for (int i = 0; i < 3; i++) begin
         if (wrst[i]) n.wcnt[i] = 16'h0000;
         else if (etu && r.wcnt[i] != 16'hffff) n.wcnt[i] = r.wcnt[i] + 16'h0001;
         viol[i] = cfg.smartcard_mode_enable && (cfg.wait_limit[i] != 16'h0000) &&
                   (r.wcnt[i] >= cfg.wait_limit[i]);
         // Clear wins its own cycle; a lasting violation sets the flag next cycle
         n.wflag[i] = cmd.wait_clr[i] ? 1'b0 : (r.wflag[i] | viol[i]);
      end

      n.bus_err = reg_sel && (reg_addr >= UFO_MAP_BYTES);

      unique case (n.tx_st)
         TX_START: n.tx_pin = 1'b0;
         TX_DATA:  n.tx_pin = n.tx_sh[n.tx_bit];
         default:  n.tx_pin = 1'b1;
      endcase
      if (n.nack_on) n.tx_pin = 1'b0;
   end

   always_ff @(posedge sys_clk) begin
      if (rst) begin
         r        <= '0;
         r.div    <= UFO_DIV_RST;
         r.tx_pin <= 1'b1;
         r.rx_s1  <= 1'b1;
         r.rx_s2  <= 1'b1;
      end else if (ce) begin
         r <= n;
      end
   end

   assign tx_pin                    = r.tx_pin;
   assign rx_data                   = r.rx_buf;
   assign rx_nack_counter           = r.nack_cnt;
   assign stat.tx_buffer_empty_flag = !r.tx_full;
   assign stat.rx_full_flag         = r.rx_full;
   assign stat.overrun_flag         = r.overrun;
   assign stat.idle_flag            = r.idle_flag;
   assign stat.match_hit            = r.match_hit;
   assign stat.bus_error            = r.bus_err;
   assign stat.char_wait_flag       = r.wflag[0];
   assign stat.block_wait_flag      = r.wflag[1];
   assign stat.general_wait_flag    = r.wflag[2];

   default clocking ufo_cb @(posedge sys_clk);
   endclocking
   default disable iff (rst);

   a_div_zero_halt: assert property (
      r.div == 13'h0000 |-> r.bcnt == 13'h0000 && !tick)
      else $error("baud generator ran with zero divisor");
   a_hi_waits_lo: assert property (
      ce && cmd.div_hi_wr && !cmd.div_lo_wr |=> r.div == $past(r.div))
      else $error("high divisor byte took effect alone");
   a_te_preamble: assert property (
      ce && cfg.tx_enable && !r.te_q |=> r.pre_pend)
      else $error("transmit enable did not queue a preamble");
   a_pre_first: assert property (
      ce && r.tx_st == TX_IDLE && cfg.tx_enable && r.pre_pend && !r.sh_valid
      |=> r.tx_st == TX_PRE)
      else $error("queued preamble did not go out ahead of new data");
   a_start_needs: assert property (
      ce && r.tx_st == TX_IDLE && !r.sh_valid |=> r.tx_st != TX_START)
      else $error("frame started with no data loaded");
   a_empty_at_load: assert property (
      ce && tick && r.tx_st == TX_STOP && r.tx_os == UFO_OS_LOAD && r.tx_full && !r.sh_valid
      && !r.pre_pend |=> r.sh_valid && stat.tx_buffer_empty_flag)
      else $error("buffer empty not set at stop-bit load point");
   a_or_blocks: assert property (
      ce && r.overrun && !cmd.or_clr && !r.rx_full && !r.idle_flag
      |=> !r.rx_full && !r.idle_flag)
      else $error("full or idle raised during overrun");
   a_or_drops: assert property (
      ce && word_done && r.overrun |=> r.rx_buf == $past(r.rx_buf))
      else $error("word stored while overrun set");
   a_or_on_loss: assert property (
      ce && word_done && !r.nack_commit && !r.overrun && full_now |=> r.overrun)
      else $error("lost word did not set overrun");
   a_nack_count: assert property (
      ce && word_done && r.nack_commit
      |=> r.nack_cnt == $past(r.nack_cnt) + 8'h01 && r.rx_buf == $past(r.rx_buf))
      else $error("nacked word not counted or not dropped");
   a_nack_no_or: assert property (
      ce && word_done && r.nack_commit && !full_now && !r.overrun |=> !r.overrun)
      else $error("overrun set though room existed for nacked word");
   a_nack_pin: assert property (
      r.nack_on |-> !tx_pin)
      else $error("nack not driven on the line");
   a_wait_again: assert property (
      ce && cmd.wait_clr[0] ##1 ce && viol[0] && !cmd.wait_clr[0] |=> stat.char_wait_flag)
      else $error("char wait flag did not reassert");
   a_idle_armed: assert property (
      ce && idle_hit |=> r.armed == !$past(rxl))
      else $error("idle redetected without a non-idle bit");
   a_match_two: assert property (
      ce && word_done && !r.nack_commit && !r.overrun && !full_now && cfg.match_en[1] &&
      r.rx_sh[7:0] == cfg.match_addr_two |=> stat.match_hit)
      else $error("second match address not recognised");
   a_bus_error: assert property (
      ce && reg_sel && reg_addr >= UFO_MAP_BYTES |=> stat.bus_error)
      else $error("invalid address gave no bus error");
endmodule : ufo_core

/* File: dv/ufo_remote.sv */
// Remote serial device model: drives the receive line and decodes the transmit line
`timescale 1ns/10ps
module ufo_remote (
   input  wire logic       sys_clk,   // Module clock, one bit is sixteen cycles
   input  wire logic       tx_pin,    // Line driven by the block
   output      logic       rx_pin,    // Line into the block, idles high
   output      logic [8:0] got_word,  // Last decoded word, bit 8 is the stop bit
   output      logic [7:0] got_cnt,   // Frames decoded so far
   output      logic       nack_seen  // Line pulled low during or after our stop bit
);
   localparam int BIT = 16;
   logic sending;

   initial begin
      rx_pin = 1'b1;
      got_word = '0;
      got_cnt = '0;
      nack_seen = 1'b0;
      sending = 1'b0;
   end

   // Start, data LSB first, stop; then listen for a nack before letting go
   task automatic send(input logic [8:0] w, input int nb);
      sending = 1'b1;
      nack_seen = 1'b0;
      rx_pin = 1'b0;
      repeat (BIT) @(negedge sys_clk);
      for (int i = 0; i < nb; i++) begin
         rx_pin = w[i];
         repeat (BIT) @(negedge sys_clk);
      end
      rx_pin = 1'b1;
      repeat (3 * BIT) begin
         @(negedge sys_clk);
         if (tx_pin === 1'b0) nack_seen = 1'b1;
      end
      sending = 1'b0;
   endtask : send

   // A nack pulse during our own frame must not be taken for a start bit
   always begin
      @(negedge tx_pin);
      if (!sending) begin
         repeat (BIT / 2) @(negedge sys_clk);
         for (int i = 0; i < 9; i++) begin
            repeat (BIT) @(negedge sys_clk);
            got_word[i] = tx_pin;
         end
         got_cnt = got_cnt + 8'h01;
      end
   end
endmodule : ufo_remote

/* File: dv/ufo_core_tb.sv */
// Self-checking bench for the serial flag and overrun controller
`timescale 1ns/10ps
module ufo_core_tb;
   import ufo_pkg::*;
   logic       sys_clk, rst, rx_pin, tx_pin, reg_sel, nack_seen, ce;
   logic [7:0] div_data, reg_addr, rx_nack_counter, got_cnt;
   logic [8:0] tx_data, rx_data, got_word;
   ufo_cfg_t   cfg;
   ufo_cmd_t   cmd;
   ufo_stat_t  stat;
   int         bad_count, tests_run, hits, n;
   time        fall_t;

   ufo_core i_dut (.sys_clk(sys_clk), .rst(rst), .ce(ce), .cfg(cfg), .cmd(cmd),
      .div_data(div_data), .tx_data(tx_data), .reg_sel(reg_sel), .reg_addr(reg_addr),
      .rx_pin(rx_pin), .tx_pin(tx_pin), .rx_data(rx_data),
      .rx_nack_counter(rx_nack_counter), .stat(stat));
   ufo_remote i_remote (.sys_clk(sys_clk), .tx_pin(tx_pin), .rx_pin(rx_pin),
      .got_word(got_word), .got_cnt(got_cnt), .nack_seen(nack_seen));

   initial begin
      sys_clk = 1'b0;
      forever #2.5 sys_clk = ~sys_clk;
   end
   always @(negedge tx_pin) fall_t = $time;
   always @(negedge sys_clk) if (stat.match_hit === 1'b1) hits++;

   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      tests_run++;
      if (got !== exp) begin
         bad_count++;
         $display("ERROR at %0t ns: got %h expected %h", $time, got, exp);
      end
   endtask : chk
   task automatic cyc(input int k);
      repeat (k) @(negedge sys_clk);
   endtask : cyc
   // Idle cycle after each strobe so back-to-back calls never retouch cmd in one step
   task automatic strobe(input ufo_cmd_t c);
      cmd = c;
      cyc(1);
      cmd = '0;
      cyc(1);
   endtask : strobe
   task automatic wait_low;
      for (n = 0; n < 1000 && tx_pin !== 1'b0; n++) cyc(1);
   endtask : wait_low

   task automatic t_baud;
      chk({tx_pin, stat}, 16'h0300);
      cfg.tx_enable = 1'b1;
      tx_data = 9'h05a;
      strobe('{tx_wr: 1'b1, default: '0});
      cyc(400);
      chk(got_cnt, 16'h0000);
      div_data = 8'h00;
      strobe('{div_hi_wr: 1'b1, default: '0});
      div_data = 8'h01;
      strobe('{div_lo_wr: 1'b1, default: '0});
      wait_low;
      chk(16'(n >= 155 && n <= 190), 16'h0001);
      cyc(200);
      chk({got_cnt, got_word[7:0]}, 16'h015a);
   endtask : t_baud

   task automatic t_tx_buffer_empty_flag;
      div_data = 8'h1f;
      strobe('{div_hi_wr: 1'b1, default: '0});
      tx_data = 9'h0ff;
      strobe('{tx_wr: 1'b1, default: '0});
      cyc(2);
      chk(stat.tx_buffer_empty_flag, 16'h0001);
      tx_data = 9'h03c;
      strobe('{tx_wr: 1'b1, default: '0});
      chk(stat.tx_buffer_empty_flag, 16'h0000);
      for (n = 0; n < 1000 && stat.tx_buffer_empty_flag !== 1'b1; n++) cyc(1);
      n = int'(($time - fall_t) / 5);
      chk(16'(n >= 150 && n <= 156), 16'h0001);
      cfg.tx_enable = 1'b0;
      cyc(1);
      cfg.tx_enable = 1'b1;
      tx_data = 9'h0a5;
      strobe('{tx_wr: 1'b1, default: '0});
      for (n = 0; n < 400 && got_cnt !== 8'h03; n++) cyc(1);
      chk({got_cnt, got_word[7:0]}, 16'h033c);
      wait_low;
      chk(16'(n >= 160 && n <= 200), 16'h0001);
      cyc(200);
      chk({got_cnt, got_word[7:0]}, 16'h04a5);
   endtask : t_tx_buffer_empty_flag

   task automatic t_overrun;
      cfg.rx_standby = 1'b1;
      i_remote.send(9'h011, 8);
      chk({stat.rx_full_flag, stat.overrun_flag, rx_data}, 16'h0411);
      cyc(200);
      chk(stat.idle_flag, 16'h0001);
      strobe('{idle_clr: 1'b1, default: '0});
      cyc(300);
      chk(stat.idle_flag, 16'h0000);
      i_remote.send(9'h022, 8);
      chk({stat.rx_full_flag, stat.overrun_flag, rx_data}, 16'h0611);
      i_remote.send(9'h033, 8);
      chk(rx_data, 16'h0011);
      strobe('{rx_rd: 1'b1, default: '0});
      i_remote.send(9'h044, 8);
      cyc(250);
      chk({stat.rx_full_flag, stat.idle_flag, stat.overrun_flag}, 16'h0001);
      strobe('{or_clr: 1'b1, default: '0});
      i_remote.send(9'h055, 8);
      chk({stat.rx_full_flag, stat.overrun_flag, rx_data}, 16'h0455);
      strobe('{rx_rd: 1'b1, default: '0});
   endtask : t_overrun

   task automatic t_nack;
      cfg.rx_standby = 1'b0;
      cfg.smartcard_mode_enable = 1'b1;
      cfg.overflow_nack_enable = 1'b1;
      i_remote.send(9'h066, 8);
      i_remote.send(9'h077, 8);
      chk({nack_seen, stat.overrun_flag, rx_nack_counter}, 16'h0301);
      chk(rx_data, 16'h0066);
      strobe('{rx_rd: 1'b1, default: '0});
      strobe('{or_clr: 1'b1, default: '0});
      i_remote.send(9'h018, 8);
      // Room is made after the nack is committed but before the word ends
      fork
         i_remote.send(9'h029, 8);
         begin
            cyc(145);
            strobe('{rx_rd: 1'b1, default: '0});
         end
      join
      chk({nack_seen, stat.overrun_flag, stat.rx_full_flag, rx_nack_counter}, 16'h0402);
      chk(rx_data, 16'h0018);
   endtask : t_nack

   task automatic t_match;
      logic [7:0] w [4] = '{8'h3c, 8'hff, 8'h5a, 8'hff};
      cfg.match_addr_one = 8'h3c;
      cfg.match_addr_two = 8'hff;
      for (int i = 0; i < 4; i++) begin
         cfg.match_en = (i == 3) ? 2'b01 : 2'b11;
         hits = 0;
         i_remote.send({1'b0, w[i]}, 8);
         strobe('{rx_rd: 1'b1, default: '0});
         chk(16'(hits), 16'(i < 2));
      end
   endtask : t_match

   task automatic t_wait;
      cfg.wait_limit = {3{16'h0004}};
      cyc(80);
      chk({stat.char_wait_flag, stat.block_wait_flag, stat.general_wait_flag}, 16'h0007);
      for (int i = 0; i < 3; i++) begin
         cmd.wait_clr[i] = 1'b1;
         cyc(1);
         cmd = '0;
         chk(stat[2 - i], 16'h0000);
         cyc(1);
         chk(stat[2 - i], 16'h0001);
      end
      fork
         i_remote.send(9'h001, 8);
         begin
            cyc(20);
            strobe('{wait_clr: 3'b101, default: '0});
            cyc(8);
            chk({stat.char_wait_flag, stat.block_wait_flag, stat.general_wait_flag}, 16'h0002);
         end
      join
      strobe('{rx_rd: 1'b1, default: '0});
      cfg.wait_limit = '0;
   endtask : t_wait

   task automatic t_buserr;
      logic [7:0] a [3] = '{8'h1f, 8'h20, 8'hff};
      for (int i = 0; i < 3; i++) begin
         reg_addr = a[i];
         reg_sel = 1'b1;
         cyc(1);
         reg_sel = 1'b0;
         chk(stat.bus_error, 16'(i > 0));
         cyc(1);
         chk(stat.bus_error, 16'h0000);
      end
      // A held clock enable must swallow the probe entirely
      ce = 1'b0;
      reg_sel = 1'b1;
      cyc(1);
      reg_sel = 1'b0;
      ce = 1'b1;
      chk(stat.bus_error, 16'h0000);
   endtask : t_buserr

   task automatic report_and_stop;
      if (bad_count == 0 && tests_run > 0) $display("All checks passed");
      else $display("Checks failed");
      $finish;
   endtask : report_and_stop

   initial begin
      cfg = '0;
      cmd = '0;
      div_data = '0;
      tx_data = '0;
      reg_sel = 1'b0;
      reg_addr = '0;
      ce = 1'b1;
      rst = 1'b1;
      bad_count = 0;
      tests_run = 0;
      hits = 0;
      cyc(4);
      rst = 1'b0;
      cyc(2);
      t_baud;
      t_tx_buffer_empty_flag;
      t_overrun;
      t_nack;
      t_match;
      t_wait;
      t_buserr;
      report_and_stop;
   end

   // The whole sequence needs about 5000 cycles; six times that means a hang
   initial begin
      repeat (30000) @(posedge sys_clk);
      bad_count++;
      report_and_stop;
   end
endmodule : ufo_core_tb
